// ===== core/ipll_defines.vh
/*
 Holds the constants of the integer synthesizer digital core: serial word
 layout, diagnostic select codes and the lock filter timing.
 Assumes it is included by its bare name from the core modules.
*/
`ifndef IPLL_DEFINES_VH
`define IPLL_DEFINES_VH

// ==========================================================================
// Widths
// ==========================================================================
`define IPLL_PRI_W 20
`define IPLL_AUX_W 8
`define IPLL_M_W 9
`define IPLL_A_W 4
`define IPLL_R_W 6

// ==========================================================================
// Primary word field positions (LSB of each field)
// ==========================================================================
`define IPLL_R_LSB 0
`define IPLL_M_LSB 6
`define IPLL_A_LSB 15

// ==========================================================================
// Auxiliary word fields and diagnostic select codes
// ==========================================================================
`define IPLL_DSEL_LSB 0
`define IPLL_DSEL_W 2
`define IPLL_DSEL_OFF 2'h0
`define IPLL_DSEL_MAIN 2'h1
`define IPLL_DSEL_REF 2'h2
`define IPLL_DSEL_MOD 2'h3

// ==========================================================================
// Reset values
// ==========================================================================
`define IPLL_PRI_RST 20'h00000
`define IPLL_AUX_RST 8'h00

// ==========================================================================
// Timing
// ==========================================================================
`define IPLL_CLK_PERIOD_NS 8
`define IPLL_LOCK_TIME_NS 1000
`define IPLL_LOCK_CYCLES ((`IPLL_LOCK_TIME_NS + `IPLL_CLK_PERIOD_NS - 1) / `IPLL_CLK_PERIOD_NS)
`define IPLL_LOCK_CNT_W 12

`endif

// ===== core/ipll_phase_cmp.v
/*
 Holds the three-state phase frequency comparator.
 Assumes one-cycle edge events from the divided reference and divided VCO,
 both already in the i_clk domain.
*/
`timescale 1ns/1ps

module ipll_phase_cmp (
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_ref_evt,
  input wire i_vco_evt,
  output reg o_up,
  output reg o_down
);

  // ========================================================================
  // Comparator state
  // ========================================================================
  reg up_next;
  reg down_next;

  always @* begin
    up_next = o_up;
    down_next = o_down;
    if (i_ref_evt && i_vco_evt) begin
      up_next = 1'b0;
      down_next = 1'b0;
    end else if (i_vco_evt) begin
      // A VCO edge either ends a pending lag or starts a lead.
      if (o_down) begin
        down_next = 1'b0;
      end else begin
        up_next = 1'b1;
      end
    end else if (i_ref_evt) begin
      if (o_up) begin
        up_next = 1'b0;
      end else begin
        down_next = 1'b1;
      end
    end
  end

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_up <= 1'b0;
      o_down <= 1'b0;
    end else begin
      o_up <= up_next;
      o_down <= down_next;
    end
  end

endmodule // ipll_phase_cmp

// ===== core/ipll_core.v
/*
 Holds the digital core of an integer-N synthesizer: interface mode select,
 serial load path, reference and main dividers with swallow control, phase
 comparator output select, lock detection and the diagnostic output.
 Assumes every pin input is asynchronous to i_clk; the serial clock and the
 prescaler output are sampled and edge-detected here, so each must stay
 high and low for at least two i_clk periods.
*/
`timescale 1ns/1ps
`include "ipll_defines.vh"

module ipll_core #(
  parameter LOCK_CYCLES = `IPLL_LOCK_CYCLES
) (
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_ser_clk,
  input wire i_ser_data,
  input wire i_reg_sel,
  input wire i_freq_load,
  input wire i_direct_mode,
  input wire i_pump_output_select,
  input wire i_feature_mode_n,
  input wire [`IPLL_M_W-1:0] i_main_pins,
  input wire [`IPLL_A_W-1:0] i_swallow_pins,
  input wire [`IPLL_R_W-1:0] i_ref_pins,
  input wire i_ref_in,
  input wire i_prescaler_in,
  output reg o_pump_up,
  output reg o_pump_down,
  output reg o_phase_up_n,
  output reg o_phase_down_n,
  output reg o_lock_filter_node,
  output wire o_lock_indicator,
  output reg o_lock_indicator_oe_n,
  output reg o_modulus_select,
  output reg o_diag_out
);

  // ========================================================================
  // Input synchronisers and edge detection
  // ========================================================================
  localparam SYNC_W = 9 + `IPLL_M_W + `IPLL_A_W + `IPLL_R_W;
  localparam [`IPLL_LOCK_CNT_W-1:0] LOCK_MAX = LOCK_CYCLES;
  localparam [`IPLL_LOCK_CNT_W-1:0] LOCK_STEP = 1;
  localparam [`IPLL_R_W-1:0] REF_STEP = 1;
  localparam [`IPLL_M_W-1:0] MAIN_STEP = 1;

  reg [SYNC_W-1:0] sync1_reg;
  reg [SYNC_W-1:0] sync2_reg;
  reg ser_clk_prev_reg;
  reg freq_load_prev_reg;
  reg ref_prev_reg;
  reg vco_prev_reg;

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      sync1_reg <= {SYNC_W{1'b0}};
      sync2_reg <= {SYNC_W{1'b0}};
    end else begin
      sync1_reg <= {i_ser_clk, i_ser_data, i_reg_sel, i_freq_load, i_direct_mode,
        i_pump_output_select, i_feature_mode_n, i_ref_in, i_prescaler_in,
        i_main_pins, i_swallow_pins, i_ref_pins};
      sync2_reg <= sync1_reg;
    end
  end

  wire [`IPLL_R_W-1:0] ref_pins_s = sync2_reg[`IPLL_R_W-1:0];
  wire [`IPLL_A_W-1:0] swallow_pins_s = sync2_reg[`IPLL_R_W +: `IPLL_A_W];
  wire [`IPLL_M_W-1:0] main_pins_s = sync2_reg[`IPLL_R_W+`IPLL_A_W +: `IPLL_M_W];
  wire prescaler_s = sync2_reg[SYNC_W-9];
  wire ref_s = sync2_reg[SYNC_W-8];
  wire feature_mode_n_s = sync2_reg[SYNC_W-7];
  wire pump_sel_s = sync2_reg[SYNC_W-6];
  wire direct_mode_s = sync2_reg[SYNC_W-5];
  wire freq_load_s = sync2_reg[SYNC_W-4];
  wire reg_sel_s = sync2_reg[SYNC_W-3];
  wire ser_data_s = sync2_reg[SYNC_W-2];
  wire ser_clk_s = sync2_reg[SYNC_W-1];

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      ser_clk_prev_reg <= 1'b0;
      freq_load_prev_reg <= 1'b0;
      ref_prev_reg <= 1'b0;
      vco_prev_reg <= 1'b0;
    end else begin
      ser_clk_prev_reg <= ser_clk_s;
      freq_load_prev_reg <= freq_load_s;
      ref_prev_reg <= ref_s;
      vco_prev_reg <= prescaler_s;
    end
  end

  wire ser_clk_rise = ser_clk_s & ~ser_clk_prev_reg;
  wire freq_load_rise = freq_load_s & ~freq_load_prev_reg;
  wire ref_rise = ref_s & ~ref_prev_reg;
  wire vco_rise = prescaler_s & ~vco_prev_reg;

  // ========================================================================
  // Serial load path
  // ========================================================================
  reg [`IPLL_PRI_W-1:0] pri_shift_reg;
  reg [`IPLL_AUX_W-1:0] aux_shift_reg;
  reg [`IPLL_PRI_W-1:0] freq_active_reg;

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      pri_shift_reg <= `IPLL_PRI_RST;
      aux_shift_reg <= `IPLL_AUX_RST;
      freq_active_reg <= `IPLL_PRI_RST;
    end else begin
      if (ser_clk_rise && !reg_sel_s) begin
        // First bit in ends up in bit 0 after a full word.
        pri_shift_reg <= {ser_data_s, pri_shift_reg[`IPLL_PRI_W-1:1]};
      end
      if (ser_clk_rise && reg_sel_s) begin
        aux_shift_reg <= {ser_data_s, aux_shift_reg[`IPLL_AUX_W-1:1]};
      end
      if (freq_load_rise) begin
        freq_active_reg <= pri_shift_reg;
      end
    end
  end

  // ========================================================================
  // Counter value select
  // ========================================================================
  wire [`IPLL_M_W-1:0] main_val = direct_mode_s ? main_pins_s :
    freq_active_reg[`IPLL_M_LSB +: `IPLL_M_W];
  wire [`IPLL_A_W-1:0] swallow_val = direct_mode_s ? swallow_pins_s :
    freq_active_reg[`IPLL_A_LSB +: `IPLL_A_W];
  wire [`IPLL_R_W-1:0] ref_val = direct_mode_s ? ref_pins_s :
    freq_active_reg[`IPLL_R_LSB +: `IPLL_R_W];
  wire [`IPLL_DSEL_W-1:0] diag_sel = feature_mode_n_s ? `IPLL_DSEL_OFF :
    aux_shift_reg[`IPLL_DSEL_LSB +: `IPLL_DSEL_W];

  // ========================================================================
  // Reference and main dividers
  // ========================================================================
  reg [`IPLL_R_W-1:0] ref_cnt_reg;
  reg [`IPLL_M_W-1:0] main_cnt_reg;
  reg ref_div_reg;
  reg main_div_reg;

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      ref_cnt_reg <= {`IPLL_R_W{1'b0}};
      main_cnt_reg <= {`IPLL_M_W{1'b0}};
      ref_div_reg <= 1'b0;
      main_div_reg <= 1'b0;
      o_modulus_select <= 1'b0;
    end else begin
      ref_div_reg <= 1'b0;
      main_div_reg <= 1'b0;
      if (ref_rise) begin
        if (ref_cnt_reg >= ref_val) begin
          ref_cnt_reg <= {`IPLL_R_W{1'b0}};
          ref_div_reg <= 1'b1;
        end else begin
          ref_cnt_reg <= ref_cnt_reg + REF_STEP;
        end
      end
      if (vco_rise) begin
        if (main_cnt_reg >= main_val) begin
          main_cnt_reg <= {`IPLL_M_W{1'b0}};
          main_div_reg <= 1'b1;
        end else begin
          main_cnt_reg <= main_cnt_reg + MAIN_STEP;
        end
      end
      // The higher modulus holds for the first swallow-count cycles.
      o_modulus_select <= ({{(`IPLL_M_W-`IPLL_A_W){1'b0}}, swallow_val} >
        main_cnt_reg);
    end
  end

  // ========================================================================
  // Phase comparator and output select
  // ========================================================================
  wire cmp_up;
  wire cmp_down;

  ipll_phase_cmp u_phase_cmp (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_ref_evt(ref_div_reg),
    .i_vco_evt(main_div_reg),
    .o_up(cmp_up),
    .o_down(cmp_down)
  );

  reg [`IPLL_LOCK_CNT_W-1:0] lock_cnt_reg;
  reg filtered_reg;

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_pump_up <= 1'b0;
      o_pump_down <= 1'b0;
      o_phase_up_n <= 1'b1;
      o_phase_down_n <= 1'b1;
      o_lock_filter_node <= 1'b0;
      lock_cnt_reg <= {`IPLL_LOCK_CNT_W{1'b0}};
      filtered_reg <= 1'b1;
      o_lock_indicator_oe_n <= 1'b0;
      o_diag_out <= 1'b0;
    end else begin
      o_pump_up <= pump_sel_s & cmp_up;
      o_pump_down <= pump_sel_s & cmp_down;
      o_phase_up_n <= ~(~pump_sel_s & cmp_up);
      o_phase_down_n <= ~(~pump_sel_s & cmp_down);
      o_lock_filter_node <= ~((~cmp_up) & (~cmp_down));
      // The filter clears only after the node has stayed low long enough.
      if (o_lock_filter_node) begin
        lock_cnt_reg <= {`IPLL_LOCK_CNT_W{1'b0}};
        filtered_reg <= 1'b1;
      end else if (lock_cnt_reg >= LOCK_MAX - LOCK_STEP) begin
        filtered_reg <= 1'b0;
      end else begin
        lock_cnt_reg <= lock_cnt_reg + LOCK_STEP;
      end
      o_lock_indicator_oe_n <= ~filtered_reg;
      case (diag_sel)
        `IPLL_DSEL_MAIN: o_diag_out <= main_div_reg;
        `IPLL_DSEL_REF: o_diag_out <= ref_div_reg;
        `IPLL_DSEL_MOD: o_diag_out <= o_modulus_select;
        default: o_diag_out <= 1'b0;
      endcase
    end
  end

  assign o_lock_indicator = 1'b0;

endmodule // ipll_core

// ===== dv/ipll_core_chk.sv
/*
 Checker bound to the ports of ipll_core.
 Assumes one clock i_clk and a synchronous active-high reset i_sys_rst.
*/
`timescale 1ns/1ps
`include "ipll_defines.vh"

module ipll_core_chk #(
  parameter LOCK_CYCLES = `IPLL_LOCK_CYCLES
) (
  input i_clk,
  input i_sys_rst,
  input i_ser_clk,
  input i_ser_data,
  input i_reg_sel,
  input i_freq_load,
  input i_direct_mode,
  input i_pump_output_select,
  input i_feature_mode_n,
  input [`IPLL_M_W-1:0] i_main_pins,
  input [`IPLL_A_W-1:0] i_swallow_pins,
  input [`IPLL_R_W-1:0] i_ref_pins,
  input i_ref_in,
  input i_prescaler_in,
  input o_pump_up,
  input o_pump_down,
  input o_phase_up_n,
  input o_phase_down_n,
  input o_lock_filter_node,
  input o_lock_indicator,
  input o_lock_indicator_oe_n,
  input o_modulus_select,
  input o_diag_out
);
  reg [11:0] low_cnt_reg;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  // ==========================================================================
  // Helper
  // ==========================================================================
  // Counts the cycles for which the lock filter node has stayed low.
  always @(posedge i_clk) begin
    if (i_sys_rst || o_lock_filter_node) begin
      low_cnt_reg <= 12'h000;
    end else if (low_cnt_reg != 12'hFFF) begin
      low_cnt_reg <= low_cnt_reg + 12'h001;
    end
  end
  // ==========================================================================
  // Assertions
  // ==========================================================================
  AST_PUMP_OFF: assert property (!i_pump_output_select [*5] |-> !o_pump_up && !o_pump_down)
    else $error("pump output active while deselected");
  AST_PHASE_OFF: assert property (i_pump_output_select [*5] |-> o_phase_up_n && o_phase_down_n)
    else $error("phase output active while pump selected");
  AST_EXCL: assert property (!(o_pump_up && o_pump_down) && !(!o_phase_up_n && !o_phase_down_n))
    else $error("up and down active together");
  AST_NODE_NAND: assert property ((o_pump_up || o_pump_down || !o_phase_up_n || !o_phase_down_n) [*2]
    |-> (o_lock_filter_node || $past(o_lock_filter_node))) else $error("node low during pulse");
  AST_NODE_IDLE: assert property (!o_lock_filter_node [*3] |-> !o_pump_up && !o_pump_down)
    else $error("pump active with node low");
  AST_LOCK_DRIVE: assert property (o_lock_filter_node |-> ##[1:3] !o_lock_indicator_oe_n)
    else $error("lock indicator not driven low");
  AST_LOCK_RELEASE: assert property (low_cnt_reg > LOCK_CYCLES + 3 |-> o_lock_indicator_oe_n)
    else $error("lock indicator not released");
  AST_LOCK_HOLD: assert property ($rose(o_lock_indicator_oe_n) |-> low_cnt_reg >= LOCK_CYCLES)
    else $error("lock indicator released early");
  AST_OD_LOW: assert property (o_lock_indicator == 1'b0)
    else $error("lock indicator data not low");
  AST_DIAG_OFF: assert property (i_feature_mode_n [*5] |-> !o_diag_out)
    else $error("diagnostic active with feature mode off");
  cover property (o_pump_up);
  cover property (!o_phase_down_n);
  cover property ($rose(o_lock_indicator_oe_n));
  cover property (o_diag_out);
endmodule // ipll_core_chk

bind ipll_core ipll_core_chk #(.LOCK_CYCLES(LOCK_CYCLES)) u_chk (.i_clk, .i_sys_rst, .i_ser_clk,
  .i_ser_data, .i_reg_sel, .i_freq_load, .i_direct_mode, .i_pump_output_select,
  .i_feature_mode_n, .i_main_pins, .i_swallow_pins, .i_ref_pins, .i_ref_in, .i_prescaler_in,
  .o_pump_up, .o_pump_down, .o_phase_up_n, .o_phase_down_n, .o_lock_filter_node,
  .o_lock_indicator, .o_lock_indicator_oe_n, .o_modulus_select, .o_diag_out);

// ===== dv/ipll_host_model.sv
/*
 Host model driving the serial programming pins.
 Assumes the bench calls its tasks; the clock stands low and data falls to
 its pull-down level outside transfers.
*/
`timescale 1ns/1ps

module ipll_host_model (
  output reg o_ser_clk,
  output reg o_ser_data,
  output reg o_reg_sel,
  output reg o_freq_load
);
  initial begin
    o_ser_clk = 1'b0;
    o_ser_data = 1'b0;
    o_reg_sel = 1'b0;
    o_freq_load = 1'b0;
  end
  task shift_bit(input b);
    begin
      o_ser_data = b;
      #40 o_ser_clk = 1'b1;
      #40 o_ser_clk = 1'b0;
    end
  endtask
  task send_pri(input [19:0] w);
    integer i;
    begin
      o_reg_sel = 1'b0;
      for (i = 0; i < 20; i = i + 1) begin
        shift_bit(w[i]);
      end
      o_ser_data = 1'b0;
      #40 o_freq_load = 1'b1;
      #40 o_freq_load = 1'b0;
    end
  endtask
  task send_aux(input [7:0] w);
    integer i;
    begin
      o_reg_sel = 1'b1;
      for (i = 0; i < 8; i = i + 1) begin
        shift_bit(w[i]);
      end
      o_ser_data = 1'b0;
      #40 o_reg_sel = 1'b0;
    end
  endtask
endmodule // ipll_host_model

// ===== dv/tb_top.sv
/*
 Self-checking bench for ipll_core: comparator rows, divider rows, reset.
 Assumes the host model drives the serial pins and the checker is bound.
*/
`timescale 1ns/1ps
`include "ipll_defines.vh"

module tb_top;
  reg i_clk = 1'b0;
  reg i_sys_rst = 1'b1;
  reg i_direct_mode = 1'b1;
  reg i_pump_output_select = 1'b0;
  reg i_feature_mode_n = 1'b0;
  reg [`IPLL_M_W-1:0] i_main_pins = 9'h000;
  reg [`IPLL_A_W-1:0] i_swallow_pins = 4'h1;
  reg [`IPLL_R_W-1:0] i_ref_pins = 6'h00;
  reg i_ref_in = 1'b0;
  reg i_prescaler_in = 1'b0;
  reg count_en = 1'b0;
  wire i_ser_clk, i_ser_data, i_reg_sel, i_freq_load;
  wire o_pump_up, o_pump_down, o_phase_up_n, o_phase_down_n, o_lock_filter_node;
  wire o_lock_indicator, o_lock_indicator_oe_n, o_modulus_select, o_diag_out;
  wire [5:0] outs = {o_pump_up, o_pump_down, o_phase_up_n, o_phase_down_n,
    o_lock_filter_node, o_lock_indicator_oe_n};
  integer n_errors = 0;
  integer n_compared = 0;
  integer n_pulse = 0;
  integer i;
  // Rows: select, lead (0 divided VCO, 1 reference, 2 both), expected outputs.
  reg [8:0] cmp_rows [0:5] = '{9'h12E, 9'h15E, 9'h006, 9'h04A, 9'h18D, 9'h08D};
  // Rows: direct mode, feature mode, diagnostic select, expected pulse count.
  reg [7:0] div_rows [0:5] = '{8'hA2, 8'h94, 8'h24, 8'h13, 8'hE0, 8'h80};

  ipll_host_model host (.o_ser_clk(i_ser_clk), .o_ser_data(i_ser_data),
    .o_reg_sel(i_reg_sel), .o_freq_load(i_freq_load));
  ipll_core #(.LOCK_CYCLES(4)) uut (.i_clk, .i_sys_rst, .i_ser_clk, .i_ser_data, .i_reg_sel,
    .i_freq_load, .i_direct_mode, .i_pump_output_select, .i_feature_mode_n, .i_main_pins,
    .i_swallow_pins, .i_ref_pins, .i_ref_in, .i_prescaler_in, .o_pump_up, .o_pump_down,
    .o_phase_up_n, .o_phase_down_n, .o_lock_filter_node, .o_lock_indicator,
    .o_lock_indicator_oe_n, .o_modulus_select, .o_diag_out);

  initial begin
    forever #4 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    if (!count_en) begin
      n_pulse <= 0;
    end else if (o_diag_out !== 1'b0) begin
      n_pulse <= n_pulse + 1;
    end
  end
  task cmp_out(input [5:0] exp);
    begin
      n_compared = n_compared + 1;
      if (outs !== exp) begin
        n_errors = n_errors + 1;
        $display("MISMATCH t=%0t outputs %b expected %b", $time, outs, exp);
      end
    end
  endtask
  task cmp_cnt(input integer exp);
    begin
      n_compared = n_compared + 1;
      if (n_pulse != exp) begin
        n_errors = n_errors + 1;
        $display("MISMATCH t=%0t pulses %0d expected %0d", $time, n_pulse, exp);
      end
    end
  endtask
  task cmp_mod(input [1:0] exp);
    begin
      n_compared = n_compared + 1;
      if ({o_modulus_select, o_diag_out} !== exp) begin
        n_errors = n_errors + 1;
        $display("MISMATCH t=%0t modsel/diag %b expected %b", $time,
          {o_modulus_select, o_diag_out}, exp);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
        $display("*** PASS ***");
      end else begin
        $display("*** FAIL ***");
      end
      $finish;
    end
  endtask
  task pulse_in(input v, input r);
    begin
      @(negedge i_clk);
      i_prescaler_in = v;
      i_ref_in = r;
      repeat (4) @(negedge i_clk);
      i_prescaler_in = 1'b0;
      i_ref_in = 1'b0;
      repeat (4) @(negedge i_clk);
    end
  endtask
  initial begin
    #200000;
    n_errors = n_errors + 1;
    give_verdict;
  end
  initial begin
    repeat (16) @(negedge i_clk);
    i_sys_rst = 1'b0;
    repeat (16) @(negedge i_clk);
    for (i = 0; i < 6; i = i + 1) begin
      i_pump_output_select = cmp_rows[i][8];
      repeat (8) @(negedge i_clk);
      pulse_in(cmp_rows[i][7:6] != 2'h1, cmp_rows[i][7:6] != 2'h0);
      repeat (4) @(negedge i_clk);
      cmp_out(cmp_rows[i][5:0]);
      pulse_in(cmp_rows[i][7:6] == 2'h1, cmp_rows[i][7:6] == 2'h0);
      repeat (8) @(negedge i_clk);
      cmp_out(6'h0D);
      $display("comparator row %0d done", i);
    end
    i_ref_pins = 6'h05;
    i_main_pins = 9'h002;
    host.send_pri({1'b0, 4'h1, 9'h003, 6'h02});
    for (i = 0; i < 6; i = i + 1) begin
      i_direct_mode = div_rows[i][7];
      i_feature_mode_n = div_rows[i][6];
      host.send_aux({6'h00, div_rows[i][5:4]});
      repeat (12) pulse_in(1'b1, 1'b1);
      count_en = 1'b1;
      repeat (12) pulse_in(1'b1, 1'b1);
      count_en = 1'b0;
      cmp_cnt(div_rows[i][3:0]);
      $display("divider row %0d done", i);
    end
    host.send_aux(8'h03);
    repeat (2) @(negedge i_clk);
    cmp_mod(2'h3);
    pulse_in(1'b1, 1'b0);
    cmp_mod(2'h0);
    i_swallow_pins = 4'h2;
    repeat (6) @(negedge i_clk);
    cmp_mod(2'h3);
    $display("modulus select test done");
    i_sys_rst = 1'b1;
    repeat (16) @(negedge i_clk);
    cmp_out(6'h0C);
    cmp_mod(2'h0);
    i_sys_rst = 1'b0;
    repeat (16) @(negedge i_clk);
    cmp_out(6'h0D);
    $display("reset test done");
    give_verdict;
  end
endmodule // tb_top
